// ### shared/gpd_pkg.sv
// Overview of operation
// R1 - input register returns current pin levels
// R2 - read/write output latch drives output pins
// R3 - set/clear upper half clears latch bits
// R4 - set/clear lower half sets latch bits
// R5 - set wins over clear in one write
// R6 - set/clear register holds no state
// R7 - clear register low bits clear latch
// R8 - direction bit: 0 input, 1 output
// R9 - input enable bit enables input path
// R10 - disabled input path samples as zero
// R11 - reset clears latch, direction, enable
// R12 - write-only reads zero, effect next cycle
package gpd_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int GPD_PINS = 16;
	localparam int GPD_AW = 8;
	localparam int GPD_DW = 32;
	// half boundary inside the set/clear word
	localparam int GPD_CLR_LSB = 16;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [GPD_AW-1:0] GPD_OFS_DIR = 8'h00;
	localparam logic [GPD_AW-1:0] GPD_OFS_INEN = 8'h04;
	localparam logic [GPD_AW-1:0] GPD_OFS_OUT = 8'h20;
	localparam logic [GPD_AW-1:0] GPD_OFS_SETCLR = 8'h24;
	localparam logic [GPD_AW-1:0] GPD_OFS_CLR = 8'h28;
	// input sample register has no printed offset
	localparam logic [GPD_AW-1:0] GPD_OFS_IN = 8'h1C;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] GPD_RST_PORT = 16'h0000;
	localparam logic [31:0] GPD_RD_ZERO = 32'h0000_0000;
	// bus slave states
	typedef enum logic [0:0] {GPD_IDLE, GPD_ANS} gpd_bus_e;
endpackage

// ### rtl/gpd_pin_cell.sv
`timescale 1ns/10ps
// one pin: direction, output drive, gated input sampling
module gpd_pin_cell (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// control
	input wire logic dir_i,
	input wire logic inen_i,
	input wire logic latch_i,
	// pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	// sampled value
	output logic sample_o
);
	logic sample_reg;
	logic sample_next;
	// gate the input path; disabled path forces zero
	always_comb begin
		sample_next = inen_i & pin_i; // [R10] [R9] [R1]
	end
	// sample register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sample_reg <= 1'b0;
		end else begin
			sample_reg <= sample_next;
		end
	end
	assign sample_o = sample_reg;
	// drive the latch only in output mode
	assign pin_o = latch_i;
	assign pin_oe_o = dir_i; // [R8] [R2]
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_in_gate;
		@(posedge clk_sys_i) disable iff (rst_i) !inen_i |=> !sample_o;
	endproperty
	a_in_gate: assert property (p_in_gate) else $error("disabled input sampled nonzero"); // [R10]
	property p_in_track;
		@(posedge clk_sys_i) disable iff (rst_i) (inen_i && pin_i) |=> sample_o;
	endproperty
	a_in_track: assert property (p_in_track) else $error("enabled high pin not sampled"); // [R1]
endmodule

// ### rtl/gpd_port.sv
`timescale 1ns/10ps
// 16-pin gpio port with avalon-mm register slave
module gpd_port
	import gpd_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [gpd_pkg::GPD_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [gpd_pkg::GPD_DW-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [gpd_pkg::GPD_DW-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	// pins
	input wire logic [gpd_pkg::GPD_PINS-1:0] pin_i,
	output logic [gpd_pkg::GPD_PINS-1:0] pin_o,
	output logic [gpd_pkg::GPD_PINS-1:0] pin_oe_o
);
	import gpd_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0] pin_direction_select_reg, pin_direction_select_next; // per-pin direction
	logic [15:0] pin_input_path_enable_reg, pin_input_path_enable_next; // per-pin input enable
	logic [15:0] pin_output_latch_bit_reg, pin_output_latch_bit_next; // output latch
	logic [15:0] pin_input_value; // gated samples from pin cells
	logic [31:0] rdata_reg, rdata_next; // registered read data
	logic [1:0] resp_reg, resp_next; // registered response
	gpd_bus_e bus_reg, bus_next; // bus phase
	logic acc; // request present in idle
	logic wr_go; // write accepted this cycle
	logic [15:0] pin_output_set_request; // set half of set/clear word
	logic [15:0] pin_output_clear_request; // combined clear requests
	logic [15:0] be_mask_lo, be_mask_hi; // byte-lane masks
	logic hit; // address maps to a register

	// ------------------------------------------------------------
	// bus slave: one wait cycle, answer on the second
	// ------------------------------------------------------------
	// byte lanes: only enabled bytes change state
	assign be_mask_lo = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign be_mask_hi = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}}};
	assign acc = (avs_read_i | avs_write_i) && bus_reg == GPD_IDLE;
	// waitrequest held while idle so every access sees one wait state
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) && bus_reg == GPD_IDLE;
	assign wr_go = avs_write_i && bus_reg == GPD_ANS;
	assign avs_readdata_o = rdata_reg;
	assign avs_response_o = resp_reg;

	// address decode
	always_comb begin
		case (avs_address_i)
			GPD_OFS_DIR, GPD_OFS_INEN, GPD_OFS_OUT, GPD_OFS_SETCLR, GPD_OFS_CLR, GPD_OFS_IN: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// read mux and phase; reads sample state at the accept cycle
	always_comb begin
		bus_next = bus_reg;
		rdata_next = rdata_reg;
		resp_next = resp_reg;
		case (bus_reg)
			GPD_IDLE: begin
				if (acc) begin
					bus_next = GPD_ANS;
					// unmapped address answers slave error
					resp_next = hit ? 2'b00 : 2'b10;
					rdata_next = GPD_RD_ZERO; // [R11] [R12]
					case (avs_address_i)
						GPD_OFS_DIR: rdata_next[15:0] = pin_direction_select_reg;
						GPD_OFS_INEN: rdata_next[15:0] = pin_input_path_enable_reg;
						GPD_OFS_OUT: rdata_next[15:0] = pin_output_latch_bit_reg; // [R2]
						GPD_OFS_IN: rdata_next[15:0] = pin_input_value; // [R1]
						default: rdata_next = GPD_RD_ZERO; // [R12] [R6]
					endcase
				end
			end
			GPD_ANS: begin
				bus_next = GPD_IDLE;
			end
			default: begin
				bus_next = GPD_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// register next values
	// ------------------------------------------------------------
	always_comb begin
		pin_direction_select_next = pin_direction_select_reg;
		pin_input_path_enable_next = pin_input_path_enable_reg;
		pin_output_latch_bit_next = pin_output_latch_bit_reg;
		pin_output_set_request = GPD_RST_PORT;
		pin_output_clear_request = GPD_RST_PORT;
		if (wr_go) begin
			case (avs_address_i)
				GPD_OFS_DIR: begin
					pin_direction_select_next = (pin_direction_select_reg & ~be_mask_lo)
						| (avs_writedata_i[15:0] & be_mask_lo); // [R8]
				end
				GPD_OFS_INEN: begin
					pin_input_path_enable_next = (pin_input_path_enable_reg & ~be_mask_lo)
						| (avs_writedata_i[15:0] & be_mask_lo); // [R9]
				end
				GPD_OFS_OUT: begin
					pin_output_latch_bit_next = (pin_output_latch_bit_reg & ~be_mask_lo)
						| (avs_writedata_i[15:0] & be_mask_lo); // [R2]
				end
				GPD_OFS_SETCLR: begin
					// modifier only: nothing of the word is stored
					pin_output_set_request = avs_writedata_i[15:0] & be_mask_lo; // [R4] [R6]
					pin_output_clear_request =
						avs_writedata_i[GPD_CLR_LSB+:GPD_PINS] & be_mask_hi; // [R3]
				end
				GPD_OFS_CLR: begin
					pin_output_clear_request = avs_writedata_i[15:0] & be_mask_lo; // [R7]
				end
				default: begin
					pin_output_set_request = GPD_RST_PORT;
				end
			endcase
			// clear first, then set so set has priority
			if (avs_address_i == GPD_OFS_SETCLR || avs_address_i == GPD_OFS_CLR) begin
				pin_output_latch_bit_next = (pin_output_latch_bit_reg & ~pin_output_clear_request)
					| pin_output_set_request; // [R5] [R12]
			end
		end
	end

	// registers: all control zero on reset
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_direction_select_reg <= GPD_RST_PORT; // [R11]
			pin_input_path_enable_reg <= GPD_RST_PORT; // [R11]
			pin_output_latch_bit_reg <= GPD_RST_PORT; // [R11]
			rdata_reg <= GPD_RD_ZERO;
			resp_reg <= 2'b00;
			bus_reg <= GPD_IDLE;
		end else begin
			pin_direction_select_reg <= pin_direction_select_next;
			pin_input_path_enable_reg <= pin_input_path_enable_next;
			pin_output_latch_bit_reg <= pin_output_latch_bit_next;
			rdata_reg <= rdata_next;
			resp_reg <= resp_next;
			bus_reg <= bus_next;
		end
	end

	// ------------------------------------------------------------
	// pin cells
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < GPD_PINS; gi++) begin : g_pin
			gpd_pin_cell u_cell (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.dir_i(pin_direction_select_reg[gi]),
				.inen_i(pin_input_path_enable_reg[gi]),
				.latch_i(pin_output_latch_bit_reg[gi]),
				.pin_i(pin_i[gi]),
				.pin_o(pin_o[gi]),
				.pin_oe_o(pin_oe_o[gi]),
				.sample_o(pin_input_value[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// every pin asked both ways must end up set, not just one sample pin
	property p_set_wins;
		@(posedge clk_sys_i) disable iff (rst_i)
		(wr_go && avs_address_i == GPD_OFS_SETCLR && avs_byteenable_i == 4'hF
			&& |(avs_writedata_i[15:0] & avs_writedata_i[GPD_CLR_LSB+:GPD_PINS]))
			|=> (pin_output_latch_bit_reg & $past(avs_writedata_i[15:0] & avs_writedata_i[GPD_CLR_LSB+:GPD_PINS]))
				== $past(avs_writedata_i[15:0] & avs_writedata_i[GPD_CLR_LSB+:GPD_PINS]);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set did not win over clear"); // [R5]
	// all requested bits of the clear word must read back low
	property p_clr_word;
		@(posedge clk_sys_i) disable iff (rst_i)
		(wr_go && avs_address_i == GPD_OFS_CLR && avs_byteenable_i == 4'hF && |avs_writedata_i[15:0])
			|=> (pin_output_latch_bit_reg & $past(avs_writedata_i[15:0])) == GPD_RST_PORT;
	endproperty
	a_clr_word: assert property (p_clr_word) else $error("clear register did not clear"); // [R7]
	// clear-only pins of a set/clear write must go low
	property p_sc_clear;
		@(posedge clk_sys_i) disable iff (rst_i)
		(wr_go && avs_address_i == GPD_OFS_SETCLR && avs_byteenable_i == 4'hF
			&& |(avs_writedata_i[GPD_CLR_LSB+:GPD_PINS] & ~avs_writedata_i[15:0]))
			|=> (pin_output_latch_bit_reg & $past(avs_writedata_i[GPD_CLR_LSB+:GPD_PINS] & ~avs_writedata_i[15:0]))
				== GPD_RST_PORT;
	endproperty
	a_sc_clear: assert property (p_sc_clear) else $error("upper half did not clear"); // [R3]
	// every set bit of a set/clear write must read back high
	property p_sc_set;
		@(posedge clk_sys_i) disable iff (rst_i)
		(wr_go && avs_address_i == GPD_OFS_SETCLR && avs_byteenable_i == 4'hF && |avs_writedata_i[15:0])
			|=> (pin_output_latch_bit_reg & $past(avs_writedata_i[15:0])) == $past(avs_writedata_i[15:0]);
	endproperty
	a_sc_set: assert property (p_sc_set) else $error("lower half did not set"); // [R4]
	property p_wo_read;
		@(posedge clk_sys_i) disable iff (rst_i)
		(acc && avs_read_i && (avs_address_i == GPD_OFS_SETCLR || avs_address_i == GPD_OFS_CLR))
			|=> (avs_readdata_o == GPD_RD_ZERO && !avs_waitrequest_o);
	endproperty
	a_wo_read: assert property (p_wo_read) else $error("write-only read not zero"); // [R12] [R6]
	property p_hold;
		@(posedge clk_sys_i) disable iff (rst_i)
		!wr_go |=> $stable(pin_output_latch_bit_reg) && $stable(pin_direction_select_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("state changed without write"); // [R2]
	property p_oe;
		@(posedge clk_sys_i) disable iff (rst_i) pin_oe_o == pin_direction_select_reg
			&& pin_o == pin_output_latch_bit_reg;
	endproperty
	a_oe: assert property (p_oe) else $error("pin drive mismatch"); // [R8]
	property p_rst;
		@(posedge clk_sys_i) rst_i |=> (pin_oe_o == GPD_RST_PORT && pin_input_path_enable_reg == GPD_RST_PORT);
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong"); // [R11]
	property p_in_rd;
		@(posedge clk_sys_i) disable iff (rst_i)
		(acc && avs_read_i && avs_address_i == GPD_OFS_IN) |=> avs_readdata_o[15:0] == $past(pin_input_value);
	endproperty
	a_in_rd: assert property (p_in_rd) else $error("input read mismatch"); // [R1]
	c_setclr: cover property (@(posedge clk_sys_i) wr_go && avs_address_i == GPD_OFS_SETCLR);
	c_clr: cover property (@(posedge clk_sys_i) wr_go && avs_address_i == GPD_OFS_CLR);
	c_rd_in: cover property (@(posedge clk_sys_i) acc && avs_read_i && avs_address_i == GPD_OFS_IN);
	c_err: cover property (@(posedge clk_sys_i) acc && !hit);
endmodule

// ### test/gpd_pin_model.sv
`timescale 1ns/10ps
// board circuitry on the port pins
module gpd_pin_model
	import gpd_pkg::*;
(
	// port side
	input wire logic [gpd_pkg::GPD_PINS-1:0] drive_i,
	input wire logic [gpd_pkg::GPD_PINS-1:0] drive_en_i,
	// board side
	input wire logic [gpd_pkg::GPD_PINS-1:0] ext_level_i,
	output logic [gpd_pkg::GPD_PINS-1:0] pin_level_o
);
	import gpd_pkg::*;
	// ------------------------------------------------------------
	// wire resolution
	// ------------------------------------------------------------
	// port wins where it drives, so no contention is modelled
	assign pin_level_o = (drive_en_i & drive_i) | (~drive_en_i & ext_level_i);
endmodule

// ### test/tb_gpio_port_data_direction.sv
`timescale 1ns/10ps
module tb_gpio_port_data_direction;
	import gpd_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [GPD_AW-1:0] avs_address_i = '0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [GPD_DW-1:0] avs_writedata_i = '0;
	logic [GPD_DW-1:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [1:0] avs_response_o;
	logic [GPD_PINS-1:0] pin_i;
	logic [GPD_PINS-1:0] pin_o;
	logic [GPD_PINS-1:0] pin_oe_o;
	logic [GPD_PINS-1:0] ext_level = 16'hBEEF; // board level on released pins
	logic [31:0] rd_q; // last read data
	logic [1:0] rd_r; // last response
	int failures = 0;
	int checked = 0;
	// 100 mhz clock
	always #5 clk_sys_i = ~clk_sys_i;
	gpd_port u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.avs_response_o(avs_response_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
	gpd_pin_model u_pins (.drive_i(pin_o), .drive_en_i(pin_oe_o), .ext_level_i(ext_level), .pin_level_o(pin_i));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one access; returns mid-cycle after completion, request released
	// waitrequest is sampled on rising edges only; the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= d;
		@(posedge clk_sys_i);
		while (avs_waitrequest_o !== 1'b0) begin
			@(posedge clk_sys_i);
		end
		rd_q = avs_readdata_o;
		rd_r = avs_response_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(negedge clk_sys_i);
	endtask
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		bus(1'b0, a, 32'h0000_0000);
		chk(name, exp, rd_q);
		chk("response", {30'h0000_0000, er}, {30'h0000_0000, rd_r});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("oe after reset", 32'h0000_0000, {16'h0000, pin_oe_o});
		chk("pin after reset", 32'h0000_0000, {16'h0000, pin_o});
		rdchk("dir", GPD_OFS_DIR, 32'h0000_0000, 2'b00);
		rdchk("inen", GPD_OFS_INEN, 32'h0000_0000, 2'b00);
		rdchk("out", GPD_OFS_OUT, 32'h0000_0000, 2'b00);
		rdchk("setclr", GPD_OFS_SETCLR, 32'h0000_0000, 2'b00);
		rdchk("in", GPD_OFS_IN, 32'h0000_0000, 2'b00);
	endtask
	task automatic t_out_dir();
		bus(1'b1, GPD_OFS_DIR, 32'hFFFF_FFFF);
		chk("oe", 32'h0000_FFFF, {16'h0000, pin_oe_o});
		bus(1'b1, GPD_OFS_OUT, 32'h1234_A5C3);
		chk("pin", 32'h0000_A5C3, {16'h0000, pin_o});
		rdchk("out", GPD_OFS_OUT, 32'h0000_A5C3, 2'b00);
		rdchk("dir", GPD_OFS_DIR, 32'h0000_FFFF, 2'b00);
	endtask
	// clear low nibbles, set top nibble, pin 12 asks both
	task automatic t_setclr();
		bus(1'b1, GPD_OFS_OUT, 32'h0000_00FF);
		bus(1'b1, GPD_OFS_SETCLR, 32'h1F0F_F000);
		chk("pin next cycle", 32'h0000_F0F0, {16'h0000, pin_o});
		rdchk("setclr", GPD_OFS_SETCLR, 32'h0000_0000, 2'b00);
		bus(1'b1, GPD_OFS_SETCLR, 32'h0000_0000);
		rdchk("out", GPD_OFS_OUT, 32'h0000_F0F0, 2'b00);
		bus(1'b1, GPD_OFS_CLR, 32'hFFFF_00F0);
		chk("pin after clr", 32'h0000_F000, {16'h0000, pin_o});
		rdchk("clr", GPD_OFS_CLR, 32'h0000_0000, 2'b00);
	endtask
	task automatic t_input();
		bus(1'b1, GPD_OFS_DIR, 32'h0000_0000);
		rdchk("in gated", GPD_OFS_IN, 32'h0000_0000, 2'b00);
		bus(1'b1, GPD_OFS_INEN, 32'h0000_00FF);
		rdchk("in half", GPD_OFS_IN, 32'h0000_00EF, 2'b00);
		bus(1'b1, GPD_OFS_INEN, 32'h0000_FFFF);
		rdchk("in all", GPD_OFS_IN, 32'h0000_BEEF, 2'b00);
		@(posedge clk_sys_i);
		ext_level <= 16'h1357;
		bus(1'b1, GPD_OFS_DIR, 32'h0000_FF00);
		rdchk("in mixed", GPD_OFS_IN, 32'h0000_F057, 2'b00);
		bus(1'b1, GPD_OFS_IN, 32'h0000_0000);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		rdchk("unmapped", 8'h40, 32'h0000_0000, 2'b10);
		rdchk("in kept", GPD_OFS_IN, 32'h0000_F057, 2'b00);
		rdchk("out kept", GPD_OFS_OUT, 32'h0000_F000, 2'b00);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_reset();
		t_out_dir();
		t_setclr();
		t_input();
		end_sim();
	end
	// about 30 accesses of 3 cycles; generous margin
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		failures++;
		end_sim();
	end
endmodule
